// ---- design/pdp_pkg.sv ----
// Purpose: constants and types for the pulse-division PWM DAC
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   register byte address is four times its index
package pdp_pkg;

   // ----------------------------------------------------------------
   // bus and register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 18;
   localparam int          DATA_W        = 32;
   localparam logic [15:0] IDX_CLK_SEL   = 16'hFFD0;
   localparam logic [15:0] IDX_LVL_UPPER = 16'hFFD1;
   localparam logic [15:0] IDX_LVL_LOWER = 16'hFFD2;

   // ----------------------------------------------------------------
   // reset values and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0]  CLK_SEL_RESET   = 8'hFE;
   localparam logic [7:0]  LVL_UPPER_RESET = 8'hC0;
   localparam logic [7:0]  LVL_LOWER_RESET = 8'h00;
   localparam int          SEL_BIT         = 0;
   localparam int          UPPER_MSB       = 5;
   localparam logic [7:0]  READ_ALL_ONES   = 8'hFF;

   // ----------------------------------------------------------------
   // timing: periods and step lengths in pclk cycles, level offset in resolution steps
   // ----------------------------------------------------------------
   localparam int          LEVEL_W        = 14;
   localparam int          PULSES         = 64;
   localparam int          SLOT_IDX_W     = 6;
   localparam int          SLOT_POS_W     = 8;
   localparam int          PERIOD_FAST    = 16384;
   localparam int          PERIOD_SLOW    = 32768;
   localparam int          STEP_FAST      = 1;
   localparam int          STEP_SLOW      = 2;
   localparam logic [1:0]  DIV_SLOW_LAST  = 2'(STEP_SLOW - 1);
   localparam logic [LEVEL_W:0] LEVEL_OFFSET = 15'(PULSES);

   typedef struct packed {
      logic                 period_select;
      logic [LEVEL_W-1:0]   level;
   } pdp_cfg_t;

   localparam pdp_cfg_t CFG_RESET = '{period_select: 1'b0,
                                      level: '0};

endpackage

// ---- design/pdp_pwm_dac.sv ----
// Purpose: 14-bit pulse-division PWM, used as a DAC behind a filter
// Assumes: single clock pclk; APB master holds requests until pready
// Notes:   one wait state on every APB access; all outputs registered
//
// Summary of operation
// RL1 - select 0 gives 16384-clock period, select 1 gives 32768 clocks
// RL2 - high-time step is one clock fast, two clocks slow
// RL3 - period select is write-only; register reads all ones
// RL4 - reset clears period select, fast period by default
// RL5 - level is six upper bits plus eight lower bits
// RL6 - software writes lower byte first, then upper byte
// RL7 - upper byte write latches the full 14-bit level
// RL8 - both level registers read as all ones
// RL9 - reset level is zero, upper register reads C0 stored
// RL10 - each period holds 64 pulses sharing the high time
// RL11 - total high time is (level + 64) times half input period
// RL12 - input clock period is 2 or 4 system clocks
// RL13 - software routes the port pin to PWM before setup
// RL14 - new level starts at next period boundary
// RL15 - 64 equal slots, high time spread evenly over slots
`timescale 1ns/100ps
`default_nettype none
module pdp_pwm_dac
   import pdp_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [pdp_pkg::ADDR_W-1:0] paddr,
   input  wire logic [pdp_pkg::DATA_W-1:0] pwdata,
   output logic      [pdp_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic                           pwm_out
);
   import pdp_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] byte_addr(
      input logic [15:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction

   function automatic logic [SLOT_IDX_W-1:0] bit_rev(
      input logic [SLOT_IDX_W-1:0] v);
      logic [SLOT_IDX_W-1:0] r;
      r = '0;
      for (int i = 0; i < SLOT_IDX_W; i++) begin
         r[i] = v[SLOT_IDX_W-1-i];
      end
      bit_rev = r;
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic                 pready_reg;
   logic [DATA_W-1:0]    prdata_reg;
   logic                 pslverr_reg;
   logic                 sel_clk;
   logic                 sel_upper;
   logic                 sel_lower;
   logic                 mapped;
   logic                 xfer_done;

   assign sel_clk   = (paddr == byte_addr(IDX_CLK_SEL));
   assign sel_upper = (paddr == byte_addr(IDX_LVL_UPPER));
   assign sel_lower = (paddr == byte_addr(IDX_LVL_LOWER));
   assign mapped    = sel_clk | sel_upper | sel_lower;
   assign xfer_done = psel & penable & pready_reg;

   // one wait state: answer at second edge of access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (psel && penable && !pready_reg) begin
         pready_reg  <= 1'b1;
         pslverr_reg <= ~mapped;
         // RL3 RL8 write-only reads
         if (!pwrite && mapped) begin
            prdata_reg <= {{(DATA_W-8){1'b0}}, READ_ALL_ONES};
         end else begin
            prdata_reg <= '0;
         end
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------------------------------
   // software-visible registers
   // ----------------------------------------------------------------
   logic                 sel_sw_reg;
   logic [UPPER_MSB:0]   upper_reg;
   logic [7:0]           lower_reg;
   logic                 pending_reg;
   logic [LEVEL_W-1:0]   pending_lvl_reg;
   logic                 period_start;
   logic                 wr_upper;

   assign wr_upper = xfer_done & pwrite & sel_upper;

   // RL4 clock select register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_sw_reg <= CLK_SEL_RESET[SEL_BIT];
      end else if (xfer_done && pwrite && sel_clk) begin
         sel_sw_reg <= pwdata[SEL_BIT];
      end
   end

   // RL9 RL5 level byte registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_reg <= LVL_UPPER_RESET[UPPER_MSB:0];
         lower_reg <= LVL_LOWER_RESET;
      end else if (xfer_done && pwrite) begin
         if (sel_upper) begin
            upper_reg <= pwdata[UPPER_MSB:0];
         end
         if (sel_lower) begin
            lower_reg <= pwdata[7:0];
         end
      end
   end

   // RL7 RL6 latch on upper write; new write beats boundary consume
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_reg     <= 1'b0;
         pending_lvl_reg <= '0;
      end else if (wr_upper) begin
         pending_reg     <= 1'b1;
         pending_lvl_reg <= {pwdata[UPPER_MSB:0], lower_reg};
      end else if (period_start) begin
         pending_reg     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // active configuration
   // ----------------------------------------------------------------
   pdp_cfg_t cfg_reg;

   // RL14 swap settings only between periods
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= CFG_RESET;
      end else if (period_start) begin
         cfg_reg.period_select <= sel_sw_reg;
         if (pending_reg) begin
            cfg_reg.level <= pending_lvl_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // step divider
   // ----------------------------------------------------------------
   logic [1:0] div_reg;
   logic       step_en;

   // RL12 RL2 step is half the input clock period
   assign step_en = ~cfg_reg.period_select | (div_reg == DIV_SLOW_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= '0;
      end else if (step_en) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // waveform generator
   // ----------------------------------------------------------------
   logic [LEVEL_W-1:0]    pos_reg;
   logic [SLOT_IDX_W-1:0] slot;
   logic [SLOT_POS_W-1:0] in_slot;
   logic [LEVEL_W:0]      total;
   logic [SLOT_POS_W:0]   base;
   logic                  extra;
   logic [SLOT_POS_W+1:0] high_len;
   logic                  high_now;

   // RL1 one period is 2^14 steps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_reg <= '0;
      end else if (step_en) begin
         pos_reg <= pos_reg + 14'd1;
      end
   end

   assign period_start = step_en & (&pos_reg);

   // RL15 RL10 equal slots, remainder by bit-reversed order
   assign slot     = pos_reg[LEVEL_W-1 -: SLOT_IDX_W];
   assign in_slot  = pos_reg[SLOT_POS_W-1:0];
   // RL11 level plus 64 steps per period
   assign total    = {1'b0, cfg_reg.level} + LEVEL_OFFSET;
   assign base     = total[LEVEL_W:SLOT_IDX_W];
   assign extra    = bit_rev(slot) < total[SLOT_IDX_W-1:0];
   assign high_len = {1'b0, base} + {{(SLOT_POS_W+1){1'b0}}, extra};
   assign high_now = {2'b00, in_slot} < high_len;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= high_now;
      end
   end

endmodule // pdp_pwm_dac
`default_nettype wire

// ---- testbench/pdp_monitor.sv ----
// Purpose: port checker for the PWM DAC
// Assumes: one clock, async active-low reset
// Notes:   bound to every pdp_pwm_dac instance
`timescale 1ns/100ps
`default_nettype none
module pdp_monitor
   import pdp_pkg::*;
(
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [pdp_pkg::ADDR_W-1:0] paddr,
   input wire logic [pdp_pkg::DATA_W-1:0] pwdata,
   input wire logic [pdp_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       pwm_out
);
   logic [9:0] low_cnt;
   logic       mapped;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign mapped = paddr inside {{IDX_CLK_SEL, 2'b00},
      {IDX_LVL_UPPER, 2'b00}, {IDX_LVL_LOWER, 2'b00}};
   // longest low run: one slot minus its one-step minimum high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_cnt <= '0;
      else if (pwm_out) low_cnt <= '0;
      else if (low_cnt != 10'h3FF) low_cnt <= low_cnt + 10'h001;
   end
   chk_ready_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
      else $error("pready not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_ready_cause: assert property (pready |-> psel && penable)
      else $error("pready without access phase");
   chk_read_ones: assert property (
      pready && !pwrite && mapped |-> prdata == 32'h000000FF)
      else $error("register read not all ones");
   chk_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   chk_err_alone: assert property (!pready |-> !pslverr)
      else $error("pslverr outside response");
   chk_low_run: assert property (low_cnt <= 10'd510)
      else $error("pwm low longer than one slot");
endmodule // pdp_monitor
bind pdp_pwm_dac pdp_monitor i_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pwm_out(pwm_out));
`default_nettype wire

// ---- testbench/pdp_lpf_model.sv ----
// Purpose: filter stand-in integrating pwm high time over a window
// Assumes: window length given in pclk cycles
// Notes:   any window of one period sees the same total
`timescale 1ns/100ps
`default_nettype none
module pdp_lpf_model (
   input  wire logic        pclk,
   input  wire logic        pwm_in,
   input  wire logic        start,
   input  wire logic [15:0] win_len,
   output logic      [15:0] high_time,
   output logic      [15:0] rises,
   output logic             done
);
   logic [15:0] left;
   logic        prev;
   initial begin
      left = '0;
      done = 1'b0;
   end
   always @(posedge pclk) begin
      if (start) begin
         left <= win_len;
         high_time <= '0;
         rises <= '0;
         prev <= pwm_in;
         done <= 1'b0;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
         high_time <= high_time + 16'(pwm_in);
         rises <= rises + 16'(pwm_in & ~prev);
         prev <= pwm_in;
         if (left == 16'h0001) done <= 1'b1;
      end
   end
endmodule // pdp_lpf_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the PWM DAC
// Assumes: 40 MHz pclk, reset held six cycles
// Notes:   high time measured over whole periods
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pdp_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite;
   logic              pready, pslverr, pwm_out, start, done, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [15:0]       hi, rises, win;
   logic [7:0]        up, lo;
   int                num_errors, compares, cycles;
   integer            seed;
   pdp_pwm_dac i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
   pdp_lpf_model i_lpf (.pclk(pclk), .pwm_in(pwm_out), .start(start),
      .win_len(win), .high_time(hi), .rises(rises), .done(done));
   always #12.5 pclk = ~pclk;
   function automatic logic [ADDR_W-1:0] ba(input logic [15:0] i);
      return {i, 2'b00};
   endfunction
   // high time in pclk: (level + 64) steps, a step of 1 or 2 clocks
   function automatic logic [31:0] exp_high(input logic s,
                                            input logic [13:0] v);
      return (32'(v) + 32'h40) << s;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // no limit of its own: the cycle ceiling ends a hung slave
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic measure(input logic [15:0] w);
      int n;
      win <= w;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (done !== 1'b1);
   endtask
   task automatic give_verdict();
      $display("counts: %0d compares, %0d errors", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      seed = 32'h1a08;
      {pclk, presetn, psel, penable, pwrite, start} = 6'h00;
      paddr = '0;
      pwdata = '0;
      win = '0;
      {num_errors, compares, cycles} = {32'h0, 32'h0, 32'h0};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ba(IDX_CLK_SEL), 8'h00);
      check(rd, 32'h000000FF);
      apb(1'b0, ba(IDX_LVL_LOWER), 8'h00);
      check(rd, 32'h000000FF);
      apb(1'b0, 18'h00010, 8'h00);
      check({31'h0, err}, 32'h1);
      lo = 8'($random(seed));
      apb(1'b1, ba(IDX_LVL_LOWER), lo);
      measure(16'(PERIOD_FAST));
      check({16'h0, hi}, exp_high(1'b0, 14'h0));
      check({16'h0, rises}, 32'h40);
      $display("test reset_defaults done");
      up = (8'($random(seed)) & 8'h3E) | 8'hC0;
      apb(1'b1, ba(IDX_CLK_SEL), 8'hFF);
      apb(1'b1, ba(IDX_LVL_UPPER), up);
      apb(1'b0, ba(IDX_LVL_UPPER), 8'h00);
      check(rd, 32'h000000FF);
      // new settings apply within one fast period of the write
      repeat (PERIOD_FAST + 40) @(posedge pclk);
      measure(16'(PERIOD_SLOW));
      check({16'h0, hi}, exp_high(1'b1, {up[5:0], lo}));
      check({16'h0, rises}, 32'h40);
      $display("test slow_level done");
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
